/* include/tcc_pkg.sv */
// package of constants for the three-channel timer clocking block
// Summary of operation
// - three identical channels, each with its own 16-bit up counter
// - counter advances by one on each rising edge of its selected clock
// - wrap from 0xFFFF to 0x0000 sets the counter overflow flag
// - counter value register reads the live count, no latching
// - trigger zeroes the counter at the next valid selected-clock edge
// - block mode register routes each external clock from pin or line A
// - clock source select picks five internal clocks or three external inputs
// - clock invert bit makes the channel count on opposite edges
// - burst setting gates counting while a chosen external input is high
// - clock enable and disable commands switch the channel counter clock
// - capture mode B load disables the clock when disable_on_b_load set
// - waveform mode C compare disables the clock when disable_on_c_compare set
// - while disabled, start and stop are ignored; only enable re-enables
// - status register shows a clock enabled flag while enabled
// - any trigger starts the counter clock, provided the clock is enabled
// - stop on B load in capture mode, or on C compare in waveform mode
// - block control register starts all three channels with one write
// - each channel drives its own interrupt output
// - line A input in capture, output in waveform; line B input here
// - sync acts as software trigger; block sync bit asserts all channels
// - waveform bit selects capture when clear, waveform when set
// - counter match with register C triggers when trigger_on_c_compare set
package tcc_pkg;

  // ----------------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------------
  localparam int NCH    = 3;
  localparam int CNT_W  = 16;
  localparam int PRSC_W = 10;

  // ----------------------------------------------------------------------
  // register offsets (channel n at n*0x40, block registers at 0xC0)
  // ----------------------------------------------------------------------
  localparam logic [5:0] OFF_CCR = 6'h00;
  localparam logic [5:0] OFF_CMR = 6'h04;
  localparam logic [5:0] OFF_CV  = 6'h10;
  localparam logic [5:0] OFF_RB  = 6'h18;
  localparam logic [5:0] OFF_RC  = 6'h1C;
  localparam logic [5:0] OFF_SR  = 6'h20;
  localparam logic [5:0] OFF_BCR = 6'h00;
  localparam logic [5:0] OFF_BMR = 6'h04;
  localparam logic [1:0] BLK_SEL = 2'h3;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CCR_EN      = 0;
  localparam int CCR_DIS     = 1;
  localparam int CCR_SOFTWARE_TRIGGER_CMD   = 2;
  localparam int CMR_CLKS    = 0;
  localparam int CMR_INV     = 3;
  localparam int CMR_BURST   = 4;
  localparam int CMR_STOP_ON_B_LOAD = 6;
  localparam int CMR_DISABLE_ON_B_LOAD  = 7;
  localparam int CMR_STOP_ON_C_COMPARE = 8;
  localparam int CMR_DISABLE_ON_C_COMPARE  = 9;
  localparam int CMR_TRIGGER_ON_C_COMPARE  = 14;
  localparam int CMR_WAVE    = 15;
  localparam int CMR_INTEN   = 16;
  localparam int SR_COVF     = 0;
  localparam int SR_CLOCK_ENABLED_FLAG   = 16;
  localparam int BCR_SYNC    = 0;

  // ----------------------------------------------------------------------
  // prescaler taps for internal clocks 1..5 (divide by 2,8,32,128,1024)
  // ----------------------------------------------------------------------
  localparam int TAP1 = 0;
  localparam int TAP2 = 2;
  localparam int TAP3 = 4;
  localparam int TAP4 = 6;
  localparam int TAP5 = 9;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [16:0] CMR_RST = 17'h00000;
  localparam logic [15:0] RC_RST  = 16'h0000;
  localparam logic [5:0]  BMR_RST = 6'h00;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

endpackage

/* hdl/tcc_timer.sv */
// three-channel timer with clock selection and clock control, APB slave
module tcc_timer (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic [2:0]  block_clock_pin_i,
  input  wire logic [2:0]  channel_line_a_i,
  output logic      [2:0]  channel_line_a_o,
  output logic      [2:0]  channel_line_a_oe_o,
  input  wire logic [2:0]  channel_line_b_i,
  output logic      [2:0]  channel_line_b_o,
  output logic      [2:0]  channel_line_b_oe_o,
  output logic      [2:0]  channel_int_o
);

  // ----------------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------------
  // level of the clock chosen by the clock source select field
  function automatic logic sel_level(input logic [2:0] s,
                                     input logic [9:0] p,
                                     input logic [2:0] x);
    case (s)
      3'h0:    sel_level = p[tcc_pkg::TAP1];
      3'h1:    sel_level = p[tcc_pkg::TAP2];
      3'h2:    sel_level = p[tcc_pkg::TAP3];
      3'h3:    sel_level = p[tcc_pkg::TAP4];
      3'h4:    sel_level = p[tcc_pkg::TAP5];
      3'h5:    sel_level = x[0];
      3'h6:    sel_level = x[1];
      default: sel_level = x[2];
    endcase
  endfunction

  // burst gate: none, or one of the external inputs
  function automatic logic burst_gate(input logic [1:0] b, input logic [2:0] x);
    case (b)
      2'h0:    burst_gate = 1'b1;
      2'h1:    burst_gate = x[0];
      2'h2:    burst_gate = x[1];
      default: burst_gate = x[2];
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [tcc_pkg::PRSC_W-1:0] prescale;
  logic [5:0]                 bmr;
  logic [2:0]                 clkpin_s1;
  logic [2:0]                 clkpin_s2;
  logic [2:0]                 linea_s1;
  logic [2:0]                 linea_s2;
  logic [2:0]                 linea_prev;
  logic [2:0]                 linea_val;
  logic [2:0]                 xc;
  logic [15:0]                cv        [tcc_pkg::NCH];
  logic [15:0]                rb        [tcc_pkg::NCH];
  logic [15:0]                rc        [tcc_pkg::NCH];
  logic [16:0]                cmr       [tcc_pkg::NCH];
  logic                       clk_en    [tcc_pkg::NCH];
  logic                       ovf       [tcc_pkg::NCH];
  logic                       setup;
  logic                       access;
  logic                       wr_acc;
  logic                       rd_acc;
  logic [1:0]                 a_ch;
  logic [5:0]                 a_off;
  logic                       sync_wr;
  logic [31:0]                next_rdata;
  logic                       next_err;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // channel index in the upper address bits, offset in the lower ones
  assign a_ch     = paddr_i[7:6];
  assign a_off    = paddr_i[5:0];
  assign setup    = psel_i & ~penable_i;
  assign access   = psel_i & penable_i;
  assign wr_acc   = access & pwrite_i;
  assign rd_acc   = access & ~pwrite_i;
  assign pready_o = access;  // zero wait states
  assign sync_wr  = wr_acc & (a_ch == tcc_pkg::BLK_SEL) & (a_off == tcc_pkg::OFF_BCR)
                    & pwdata_i[tcc_pkg::BCR_SYNC];

  // ----------------------------------------------------------------------
  // read data mux, sampled in the setup phase
  // ----------------------------------------------------------------------
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_err   = 1'b1;
    if (a_ch == tcc_pkg::BLK_SEL) begin
      if (a_off == tcc_pkg::OFF_BMR) begin
        next_rdata = {26'h000_0000, bmr};
        next_err   = 1'b0;
      end else if (a_off == tcc_pkg::OFF_BCR) begin
        next_err   = 1'b0;  // write-only, reads zero
      end
    end else begin
      case (a_off)
        tcc_pkg::OFF_CCR: begin
          next_err = 1'b0;
        end
        tcc_pkg::OFF_CMR: begin
          next_rdata = {15'h0000, cmr[a_ch]};
          next_err   = 1'b0;
        end
        tcc_pkg::OFF_CV: begin
          next_rdata = {16'h0000, cv[a_ch]};  // live count
          next_err   = 1'b0;
        end
        tcc_pkg::OFF_RB: begin
          next_rdata = {16'h0000, rb[a_ch]};
          next_err   = 1'b0;
        end
        tcc_pkg::OFF_RC: begin
          next_rdata = {16'h0000, rc[a_ch]};
          next_err   = 1'b0;
        end
        tcc_pkg::OFF_SR: begin
          next_rdata[tcc_pkg::SR_COVF]   = ovf[a_ch];
          next_rdata[tcc_pkg::SR_CLOCK_ENABLED_FLAG] = clk_en[a_ch];
          next_err                       = 1'b0;
        end
        default: begin
          next_err = 1'b1;
        end
      endcase
    end
  end

  // registered read data and error for the access phase
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o  <= next_rdata;
      pslverr_o <= next_err;
    end
  end

  // ----------------------------------------------------------------------
  // block mode register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      bmr <= tcc_pkg::BMR_RST;
    end else if (wr_acc && a_ch == tcc_pkg::BLK_SEL && a_off == tcc_pkg::OFF_BMR) begin
      bmr <= pwdata_i[5:0];
    end
  end

  // ----------------------------------------------------------------------
  // internal clocks from a free prescaler
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      prescale <= '0;
    end else begin
      prescale <= prescale + 10'h001;
    end
  end

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // two flops per pin; the slow pin rate keeps edges visible
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      clkpin_s1  <= 3'h0;
      clkpin_s2  <= 3'h0;
      linea_s1   <= 3'h0;
      linea_s2   <= 3'h0;
      linea_prev <= 3'h0;
    end else begin
      clkpin_s1  <= block_clock_pin_i;
      clkpin_s2  <= clkpin_s1;
      linea_s1   <= channel_line_a_i;
      linea_s2   <= linea_s1;
      linea_prev <= linea_s2;
    end
  end

  // line B is kept as input in both modes
  assign channel_line_b_o    = 3'h0;
  assign channel_line_b_oe_o = 3'h0;

  // ----------------------------------------------------------------------
  // external clock routing for chaining
  // ----------------------------------------------------------------------
  // per input: 0 pin, 1 low, 2/3 line A of the next/second-next channel
  genvar k;
  generate
    for (k = 0; k < tcc_pkg::NCH; k++) begin : g_xc
      always_comb begin
        case (bmr[2*k +: 2])
          2'h0:    xc[k] = clkpin_s2[k];
          2'h1:    xc[k] = 1'b0;
          2'h2:    xc[k] = linea_val[(k + 1) % tcc_pkg::NCH];
          default: xc[k] = linea_val[(k + 2) % tcc_pkg::NCH];
        endcase
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < tcc_pkg::NCH; c++) begin : g_ch
      logic        hit;
      logic        lvl;
      logic        lvl_prev;
      logic        cnt_edge;
      logic        run;
      logic        pend;
      logic        next_en;
      logic [15:0] next_cv;
      logic        wave;
      logic        ccr_wr;
      logic        trig;
      logic        cmp_evt;
      logic        cmp_wave;
      logic        bload;
      logic        ovf_evt;
      logic        stop_evt;
      logic        dis_evt;
      logic        line_a_q;
      logic        int_q;

      // channel decode and events
      assign hit      = (a_ch == 2'(c));
      assign wave     = cmr[c][tcc_pkg::CMR_WAVE];
      assign ccr_wr   = wr_acc & hit & (a_off == tcc_pkg::OFF_CCR);
      assign lvl      = sel_level(cmr[c][tcc_pkg::CMR_CLKS +: 3], prescale, xc)
                        ^ cmr[c][tcc_pkg::CMR_INV];
      assign cnt_edge = lvl & ~lvl_prev & clk_en[c] & run
                        & burst_gate(cmr[c][tcc_pkg::CMR_BURST +: 2], xc);
      assign next_cv  = pend ? 16'h0000 : cv[c] + 16'h0001;
      assign ovf_evt  = cnt_edge & ~pend & (cv[c] == tcc_pkg::CNT_MAX);
      assign cmp_evt  = cnt_edge & (next_cv == rc[c]);
      assign cmp_wave = cmp_evt & wave;
      assign bload    = ~wave & linea_s2[c] & ~linea_prev[c];
      assign trig     = (ccr_wr & pwdata_i[tcc_pkg::CCR_SOFTWARE_TRIGGER_CMD]) | sync_wr
                        | (cmp_evt & cmr[c][tcc_pkg::CMR_TRIGGER_ON_C_COMPARE]);
      assign stop_evt = (bload & cmr[c][tcc_pkg::CMR_STOP_ON_B_LOAD])
                        | (cmp_wave & cmr[c][tcc_pkg::CMR_STOP_ON_C_COMPARE]);
      assign dis_evt  = (ccr_wr & pwdata_i[tcc_pkg::CCR_DIS])
                        | (bload & cmr[c][tcc_pkg::CMR_DISABLE_ON_B_LOAD])
                        | (cmp_wave & cmr[c][tcc_pkg::CMR_DISABLE_ON_C_COMPARE]);

      // enable state: disable wins over enable
      always_comb begin
        next_en = clk_en[c];
        if (dis_evt) begin
          next_en = 1'b0;
        end else if (ccr_wr && pwdata_i[tcc_pkg::CCR_EN]) begin
          next_en = 1'b1;
        end
      end

      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          clk_en[c] <= 1'b0;
        end else begin
          clk_en[c] <= next_en;
        end
      end

      // start and stop act only while enabled; stop wins
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          run <= 1'b0;
        end else if (clk_en[c] && stop_evt) begin
          run <= 1'b0;
        end else if (next_en && trig) begin
          run <= 1'b1;
        end
      end

      // counter with reset deferred to the next valid edge
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          cv[c]    <= 16'h0000;
          pend     <= 1'b0;
          lvl_prev <= 1'b0;
        end else begin
          lvl_prev <= lvl;
          if (cnt_edge) begin
            cv[c] <= next_cv;
          end
          if (trig) begin
            pend <= 1'b1;
          end else if (cnt_edge) begin
            pend <= 1'b0;
          end
        end
      end

      // overflow flag, cleared by a status read, set wins
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          ovf[c] <= 1'b0;
        end else if (ovf_evt) begin
          ovf[c] <= 1'b1;
        end else if (rd_acc && hit && a_off == tcc_pkg::OFF_SR) begin
          ovf[c] <= 1'b0;
        end
      end

      // mode and compare registers
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          cmr[c] <= tcc_pkg::CMR_RST;
          rc[c]  <= tcc_pkg::RC_RST;
        end else if (wr_acc && hit) begin
          if (a_off == tcc_pkg::OFF_CMR) begin
            cmr[c] <= pwdata_i[16:0];
          end
          if (a_off == tcc_pkg::OFF_RC) begin
            rc[c] <= pwdata_i[15:0];
          end
        end
      end

      // capture B on a rising line A edge in capture mode
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          rb[c] <= 16'h0000;
        end else if (bload) begin
          rb[c] <= cv[c];
        end
      end

      // line A toggles on compare C in waveform mode
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          line_a_q <= 1'b0;
        end else if (!wave) begin
          line_a_q <= 1'b0;
        end else if (cmp_evt) begin
          line_a_q <= ~line_a_q;
        end
      end

      assign channel_line_a_o[c]    = line_a_q;
      assign channel_line_a_oe_o[c] = wave;
      assign linea_val[c]           = wave ? line_a_q : linea_s2[c];

      // interrupt output from the overflow flag and its enable
      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          int_q <= 1'b0;
        end else begin
          int_q <= ovf[c] & cmr[c][tcc_pkg::CMR_INTEN];
        end
      end

      assign channel_int_o[c] = int_q;
    end
  endgenerate

endmodule

/* verif/tcc_timer_assertions.sv */
// port-level checker for the three-channel timer, bound to its top module
module tcc_timer_assertions (
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [2:0]  channel_line_a_o,
  input wire logic [2:0]  channel_line_a_oe_o,
  input wire logic [2:0]  channel_line_b_oe_o,
  input wire logic [2:0]  channel_int_o
);
  // ------------------------------
  // helpers
  // ------------------------------
  logic setup;
  logic on_ch;
  logic cmr_wr;
  // decoded bus phases and targets
  assign setup  = psel_i & ~penable_i;
  assign on_ch  = paddr_i[7:6] != 2'h3;
  assign cmr_wr = psel_i & penable_i & pwrite_i & on_ch & (paddr_i[5:0] == tcc_pkg::OFF_CMR);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // ------------------------------
  // assertions
  // ------------------------------
  chk_zero_wait: assert property (pready_o == (psel_i & penable_i))
    else $error("pready differs from psel and penable");
  chk_reset_quiet: assert property ($rose(rstn_i) |->
    {prdata_o, pslverr_o, channel_line_a_o, channel_line_a_oe_o, channel_int_o} == 42'h0)
    else $error("outputs not cleared after reset");
  chk_oe_wave: assert property (cmr_wr |=>
    channel_line_a_oe_o[$past(paddr_i[7:6])] == $past(pwdata_i[tcc_pkg::CMR_WAVE]))
    else $error("line A enable does not follow the waveform bit");
  chk_line_b_in: assert property (channel_line_b_oe_o == 3'h0)
    else $error("line B driven");
  chk_capture_quiet: assert property ($stable(channel_line_a_oe_o) [*2] |->
    (channel_line_a_o & ~channel_line_a_oe_o) == 3'h0)
    else $error("line A output active in capture mode");
  chk_int_gate: assert property (cmr_wr && !pwdata_i[tcc_pkg::CMR_INTEN] |->
    ##2 !channel_int_o[$past(paddr_i[7:6], 2)])
    else $error("interrupt high while disabled");
  chk_unmapped_err: assert property (setup && paddr_i[5:0] == 6'h08 |=> pslverr_o)
    else $error("no error on unmapped address");
  chk_cv_mapped: assert property (setup && on_ch && paddr_i[5:0] == tcc_pkg::OFF_CV
    |=> !pslverr_o)
    else $error("error on counter read");
  chk_cmd_reads_zero: assert property (setup && !pwrite_i && paddr_i[5:0] == 6'h00
    |=> prdata_o == 32'h0)
    else $error("command register read not zero");
  chk_prdata_hold: assert property (!setup |=> $stable(prdata_o) && $stable(pslverr_o))
    else $error("read data changed outside setup");

  // main scenarios seen
  cover property (cmr_wr && pwdata_i[tcc_pkg::CMR_WAVE]);
  cover property (pslverr_o);
  cover property (channel_line_a_o != 3'h0);
endmodule

bind tcc_timer tcc_timer_assertions u_tcc_timer_assertions (
  .clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .pready_o, .pslverr_o, .channel_line_a_o, .channel_line_a_oe_o, .channel_line_b_oe_o,
  .channel_int_o
);

/* verif/tcc_ext_model.sv */
// far-side model: external clock pins and line drivers facing the timer
module tcc_ext_model #(
  parameter int HALF = 3
) (
  input  wire logic       clk_i,
  input  wire logic [2:0] run_i,
  input  wire logic [2:0] lvl_i,
  input  wire logic [2:0] pulse_i,
  output logic      [2:0] pin_o,
  output logic      [2:0] line_a_o,
  output logic      [2:0] line_b_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [3] = '{0, 0, 0};

  // start levels
  initial begin
    pin_o    = 3'h0;
    line_a_o = 3'h0;
    line_b_o = 3'h5;
  end

  // ------------------------------
  // clock pins: hold the given level, toggle every HALF cycles while run
  // ------------------------------
  always @(posedge clk_i) begin
    for (int k = 0; k < 3; k++) begin
      if (!run_i[k] || cnt[k] == HALF - 1) cnt[k] <= 0;
      else cnt[k] <= cnt[k] + 1;
      if (!run_i[k]) pin_o[k] <= lvl_i[k];
      else if (cnt[k] == HALF - 1) pin_o[k] <= ~pin_o[k];
    end
  end

  // line A follows the pulse request; line B never settles
  always @(posedge clk_i) begin
    line_a_o <= pulse_i;
    line_b_o <= ~line_b_o;
  end
endmodule

/* verif/tcc_timer_tb.sv */
// self-checking testbench of the three-channel timer
module tcc_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          LIMIT = 30000;
  localparam logic [32:0] FM    = 33'h1_FFFF_FFFF;
  localparam logic [31:0] WV    = 32'h1 << tcc_pkg::CMR_WAVE;
  localparam logic [31:0] CS    = 32'h1 << tcc_pkg::CMR_STOP_ON_C_COMPARE;
  localparam logic [31:0] CD    = 32'h1 << tcc_pkg::CMR_DISABLE_ON_C_COMPARE;
  localparam logic [31:0] CT    = 32'h1 << tcc_pkg::CMR_TRIGGER_ON_C_COMPARE;
  localparam logic [31:0] BD    = 32'h1 << tcc_pkg::CMR_DISABLE_ON_B_LOAD;
  localparam logic [31:0] IV    = 32'h1 << tcc_pkg::CMR_INV;
  localparam logic [31:0] ENA   = 32'h1 << tcc_pkg::CCR_EN;
  localparam logic [31:0] DIS   = 32'h1 << tcc_pkg::CCR_DIS;
  localparam logic [31:0] TRG   = 32'h1 << tcc_pkg::CCR_SOFTWARE_TRIGGER_CMD;
  localparam logic [31:0] CKE   = 32'h1 << tcc_pkg::SR_CLOCK_ENABLED_FLAG;
  localparam logic [5:0]  CV    = tcc_pkg::OFF_CV;
  localparam logic [5:0]  SR    = tcc_pkg::OFF_SR;
  localparam logic [5:0]  RC    = tcc_pkg::OFF_RC;
  localparam logic [5:0]  CM    = tcc_pkg::OFF_CMR;
  localparam logic [5:0]  CC    = tcc_pkg::OFF_CCR;

  logic        clk_i     = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o;
  logic [2:0]  block_clock_pin_i, channel_line_a_i, channel_line_a_o, channel_line_a_oe_o;
  logic [2:0]  channel_line_b_i, channel_line_b_o, channel_line_b_oe_o, channel_int_o, mdl_a;
  logic [2:0]  run = 3'h0, lvl = 3'h0, pulse = 3'h0, la = 3'h0;
  logic [32:0] exp_q [$];
  logic [32:0] msk_q [$];
  logic [15:0] rc;
  logic [15:0] cv [3];
  logic [1:0]  ch;
  int          div, cyc = 0, seed = 36, err_total = 0, compares = 0;

  always #2 clk_i = ~clk_i;

  // line A wire: design drives while enabled, else the far side
  assign channel_line_a_i = (channel_line_a_oe_o & channel_line_a_o) | (~channel_line_a_oe_o & mdl_a);

  tcc_timer u_tcc_timer (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .block_clock_pin_i, .channel_line_a_i, .channel_line_a_o,
    .channel_line_a_oe_o, .channel_line_b_i, .channel_line_b_o, .channel_line_b_oe_o,
    .channel_int_o);
  tcc_ext_model u_tcc_ext_model (.clk_i, .run_i(run), .lvl_i(lvl), .pulse_i(pulse),
    .pin_o(block_clock_pin_i), .line_a_o(mdl_a), .line_b_o(channel_line_b_i));

  // ------------------------------
  // bus tasks and checking
  // ------------------------------
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);  // pready is high in the first access cycle, so this ends after one cycle
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [1:0] c, input logic [5:0] o, input logic [31:0] d);
    apb(1'b1, {c, o}, d);
  endtask

  task automatic rd(input logic [1:0] c, input logic [5:0] o, input logic [32:0] e,
                    input logic [32:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    apb(1'b0, {c, o}, 32'h0);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic end_of_test();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // read results compared against the oldest note
  always @(posedge clk_i) begin
    if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1 && exp_q.size() > 0) begin
      check("read data", {pslverr_o, prdata_o} & msk_q.pop_front(), exp_q.pop_front());
    end
  end

  // hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      end_of_test();
    end
  end

  // ------------------------------
  // scenarios
  // ------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    // reset values, write-only commands, unmapped word
    for (int c = 0; c < 3; c++) begin
      rd(c[1:0], CM, {16'h0, tcc_pkg::CMR_RST}, FM);
      rd(c[1:0], RC, {17'h0, tcc_pkg::RC_RST}, FM);
      rd(c[1:0], SR, 33'h0, FM);
      rd(c[1:0], CV, 33'h0, FM);
      rd(c[1:0], CC, 33'h0, FM);
      rd(c[1:0], 6'h08, 33'h1_0000_0000, FM);
    end
    rd(2'h3, tcc_pkg::OFF_BMR, {27'h0, tcc_pkg::BMR_RST}, FM);
    // internal clocks: run to the compare value and stop, restart from zero
    for (int s = 0; s < 5; s++) begin
      ch  = 2'(s % 3);
      rc  = (16'($random(seed)) & 16'h0007) + 16'h0002;
      div = (s == 4) ? 1024 : (2 << (2 * s));
      wr(ch, RC, {16'h0, rc});
      wr(ch, CM, WV | CS | 32'(s) | ((s == 2) ? IV : 32'h0));
      wr(ch, CC, ENA | TRG);
      wt(div * (int'(rc) + 3) + 20);
      rd(ch, CV, {17'h0, rc}, FM);
      rd(ch, SR, {1'b0, CKE}, {1'b0, CKE});
      cv[ch] = rc;
      la[ch] = ~la[ch];
      check("line_a", {30'h0, channel_line_a_o}, {30'h0, la});
    end
    // compare disables the clock; triggers ignored until re-enabled
    wr(2'h1, RC, 32'h5);
    wr(2'h1, CM, WV | CD);
    wr(2'h1, CC, ENA | TRG);
    wt(40);
    rd(2'h1, CV, 33'h5, FM);
    rd(2'h1, SR, 33'h0, {1'b0, CKE});
    wr(2'h1, CC, TRG);
    wt(40);
    rd(2'h1, CV, 33'h5, FM);
    wr(2'h1, CC, ENA);
    rd(2'h1, SR, {1'b0, CKE}, {1'b0, CKE});
    wr(2'h1, CC, ENA | DIS);
    rd(2'h1, SR, 33'h0, {1'b0, CKE});
    // enable alone does not start channels 0 and 2; one block write starts all three
    for (int c = 0; c < 3; c++) begin
      wr(c[1:0], RC, 32'h7);
      wr(c[1:0], CM, WV | CS);
      wr(c[1:0], CC, ENA);
    end
    rd(2'h0, CV, {17'h0, cv[0]}, FM);
    rd(2'h2, CV, {17'h0, cv[2]}, FM);
    wr(2'h3, tcc_pkg::OFF_BCR, 32'h1 << tcc_pkg::BCR_SYNC);
    wt(40);
    for (int c = 0; c < 3; c++) rd(c[1:0], CV, 33'h7, FM);
    // external pins as counting clocks, one of them inverted
    for (int k = 0; k < 3; k++) begin
      wr(k[1:0], RC, 32'h5);
      run[k] <= 1'b1;
      wr(k[1:0], CM, WV | CS | 32'(5 + k) | ((k == 1) ? IV : 32'h0));
      wr(k[1:0], CC, ENA | TRG);
      wt(80);
      rd(k[1:0], CV, 33'h5, FM);
      run[k] <= 1'b0;
    end
    // burst gate on external input 1
    wr(2'h2, RC, 32'h3);
    run[0] <= 1'b1;
    wr(2'h2, CM, WV | CS | 32'h5 | (32'h2 << tcc_pkg::CMR_BURST));
    wr(2'h2, CC, ENA | TRG);
    wt(80);
    rd(2'h2, CV, 33'h5, FM);
    lvl[1] <= 1'b1;
    wt(80);
    rd(2'h2, CV, 33'h3, FM);
    run[0] <= 1'b0;
    // chaining: external input 0 from line A of channel 1
    wr(2'h3, tcc_pkg::OFF_BMR, 32'h2);
    wr(2'h1, RC, 32'h3);
    wr(2'h1, CM, WV | CT);
    wr(2'h1, CC, ENA | TRG);
    wr(2'h0, RC, 32'h4);
    wr(2'h0, CM, WV | CS | 32'h5);
    wr(2'h0, CC, ENA | TRG);
    wt(200);
    rd(2'h0, CV, 33'h4, FM);
    check("line_a_oe", {30'h0, channel_line_a_oe_o}, 33'h7);
    // capture mode: rising line A loads B and disables the clock
    wr(2'h1, CC, DIS);
    wr(2'h2, CM, BD);
    wr(2'h2, CC, ENA | TRG);
    check("line_a_oe", {30'h0, channel_line_a_oe_o}, 33'h3);
    rd(2'h2, SR, {1'b0, CKE}, {1'b0, CKE});
    pulse[2] <= 1'b1;
    wt(4);
    pulse[2] <= 1'b0;
    wt(10);
    rd(2'h2, SR, 33'h0, {1'b0, CKE});
    wt(5);
    end_of_test();
  end
endmodule
